// ---- verilog/itpc_ctrl.sv ----
// Interrupt and trap controller: flags, enables, priorities, arbitration and CPU level.
//
// Overview of operation
// - Eight trap vectors per table; vectors 1-4 are oscillator, address, stack, math.
// - Seventeen interrupt registers: two controls, flags, enables, priorities, vector status.
// - First control register holds nesting disable and the trap flags.
// - Second control register sets external pin edges and alternate table use.
// - Each source has a flag set by hardware and cleared only by software.
// - A user source is eligible only while its enable bit is set; traps have no enable.
// - Each user source has a writable 3-bit priority field.
// - Presented vector number latched in 7 bits, new level in 4 bits.
// - Latched new level equals the priority of the presented interrupt.
// - Flag, enable and priority bits follow vector order from vector 8.
// - Status bits 7-5 show and set the low three level bits.
// - The level top bit in core control is read-only to software.
// - Level is top bit above the three status bits, giving 0-15.
// - Level top bit set blocks all user interrupts.
// - Nesting disable makes the three status level bits ignore writes.
// - Level top bit reads 1 only when the level exceeds 7.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`include "itpc_cfg.svh"

module itpc_ctrl
  import itpc_pkg::*;
(
  // Clock and reset.
  input  wire logic          core_clk,
  input  wire logic          rstn,
  // Register port.
  input  wire itpc_addr_t    reg_addr,
  input  wire itpc_word_t    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output itpc_word_t         reg_rdata,
  // Request sources.
  input  wire logic [31:0]   periph_req,
  input  wire logic [2:0]    ext_pin,
  input  wire logic [3:0]    trap_req,
  // Processor core side.
  output logic               irq_req,
  output itpc_vec_t          irq_vector,
  output itpc_level_t        irq_level,
  output itpc_paddr_t        irq_handler,
  input  wire logic          irq_ack,
  input  wire logic          level_restore,
  input  wire itpc_level_t   restore_level,
  output itpc_level_t        cpu_priority_level,
  // Summary interrupt.
  output logic               evt_irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [31:0]  flag_q;
  logic [31:0]  flag_d;
  logic [31:0]  en_q;
  itpc_word_t   pri_q [0:7];
  logic [3:0]   trap_q;
  logic [3:0]   trap_d;
  logic         nest_dis_q;
  logic         alt_sel_q;
  logic [2:0]   ext_pol_q;
  logic [2:0]   sync1_q;
  logic [2:0]   sync2_q;
  logic [2:0]   prev_q;
  itpc_level_t  level_q;
  itpc_level_t  level_d;
  logic         req_q;
  itpc_vec_t    latched_vector_number_q;
  itpc_level_t  ilr_q;
  itpc_paddr_t  handler_q;
  logic [1:0]   est_q;
  logic [1:0]   est_d;
  logic [1:0]   emask_q;
  itpc_word_t   rdata_q;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  wire w_c1   = reg_wr && (reg_addr == `ITPC_A_CTRL_ONE);
  wire w_c2   = reg_wr && (reg_addr == `ITPC_A_CTRL_TWO);
  wire w_f0   = reg_wr && (reg_addr == `ITPC_A_FLAG0);
  wire w_f1   = reg_wr && (reg_addr == `ITPC_A_FLAG1);
  wire w_e0   = reg_wr && (reg_addr == `ITPC_A_EN0);
  wire w_e1   = reg_wr && (reg_addr == `ITPC_A_EN1);
  wire w_pri  = reg_wr && (reg_addr >= `ITPC_A_PRI_FIRST) && (reg_addr <= `ITPC_A_PRI_LAST);
  wire w_sr   = reg_wr && (reg_addr == `ITPC_A_CPU_STATUS);
  wire w_est  = reg_wr && (reg_addr == `ITPC_A_EVT_STAT);
  wire w_emsk = reg_wr && (reg_addr == `ITPC_A_EVT_MASK);
  wire take   = req_q && irq_ack;

  // --------------------------------------------------------------------------
  // External pins: synchronise, then detect the selected edge
  // --------------------------------------------------------------------------
  // Polarity 0 catches a rising edge, 1 a falling edge.
  wire [2:0]  ext_rise = sync2_q & ~prev_q;
  wire [2:0]  ext_fall = ~sync2_q & prev_q;
  wire [2:0]  ext_evt  = (ext_rise & ~ext_pol_q) | (ext_fall & ext_pol_q);
  wire [31:0] ext_set  = ({31'h0, ext_evt[0]} << `ITPC_EXT0_SRC) |
                         ({31'h0, ext_evt[1]} << `ITPC_EXT1_SRC) |
                         ({31'h0, ext_evt[2]} << `ITPC_EXT2_SRC);
  wire [31:0] src_set  = periph_req | ext_set;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q  <= 3'h0;
    end else begin
      sync1_q <= ext_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // --------------------------------------------------------------------------
  // Flags: hardware sets, software clears, and a set in the clear cycle wins
  // --------------------------------------------------------------------------
  wire [31:0] flag_wr = {w_f1 ? reg_wdata : flag_q[31:16], w_f0 ? reg_wdata : flag_q[15:0]};
  assign flag_d = flag_wr | src_set;
  wire [3:0] trap_wr = w_c1 ? reg_wdata[4:1] : trap_q;
  assign trap_d = trap_wr | trap_req;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= 32'h0;
      trap_q <= 4'h0;
    end else begin
      flag_q <= flag_d;
      trap_q <= trap_d;
    end
  end

  // Enables, priorities and global controls are plain storage.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_q       <= 32'h0;
      nest_dis_q <= 1'b0;
      alt_sel_q  <= 1'b0;
      ext_pol_q  <= 3'h0;
      for (int k = 0; k < 8; k++) begin
        pri_q[k] <= `ITPC_RST_WORD;
      end
    end else begin
      if (w_e0) en_q[15:0] <= reg_wdata;
      if (w_e1) en_q[31:16] <= reg_wdata;
      if (w_pri) pri_q[reg_addr[2:0]] <= reg_wdata & `ITPC_PRI_MASK;
      if (w_c1) nest_dis_q <= reg_wdata[`ITPC_NEST_DIS_BIT];
      if (w_c2) begin
        alt_sel_q <= reg_wdata[`ITPC_ALT_SEL_BIT];
        ext_pol_q <= reg_wdata[2:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // User arbitration chain
  // --------------------------------------------------------------------------
  // A strict compare keeps the earlier source on a tie, so vector order breaks ties.
  // Priority zero never beats level zero, so a zero field parks its source for good.
  itpc_pri_t  bp_w [0:32];
  logic [4:0] bi_w [0:32];
  logic       bo_w [0:32];
  assign bp_w[0] = 3'h0;
  assign bi_w[0] = 5'h00;
  assign bo_w[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < `ITPC_NSRC; g++) begin : g_arb
      wire itpc_pri_t pri  = pri_q[g / 4][(g % 4) * 4 +: 3];
      wire            cand = flag_q[g] && en_q[g] && ({1'b0, pri} > level_q);
      wire            win  = cand && (!bo_w[g] || (pri > bp_w[g]));
      assign bp_w[g + 1] = win ? pri : bp_w[g];
      assign bi_w[g + 1] = win ? 5'(g) : bi_w[g];
      assign bo_w[g + 1] = bo_w[g] || cand;
    end
  endgenerate

  // Level top bit set means the compare above already fails for every 3-bit priority.
  wire        user_hit = bo_w[32] && !level_q[`ITPC_IPL_MSB_BIT];
  wire [2:0]  best_pri = bp_w[32];

  // --------------------------------------------------------------------------
  // Trap selection
  // --------------------------------------------------------------------------
  // The lowest flagged trap vector wins; traps sit above every user level.
  wire        trap_hit = (|trap_q) && (`ITPC_TRAP_LEVEL > level_q);
  wire [6:0]  trap_vec = trap_q[0] ? 7'h01 : trap_q[1] ? 7'h02 : trap_q[2] ? 7'h03 : 7'h04;
  wire        any_hit  = trap_hit || user_hit;
  wire [6:0]  sel_vec  = trap_hit ? trap_vec : (`ITPC_USER_VEC0 + {2'h0, bi_w[32]});
  wire [3:0]  sel_lvl  = trap_hit ? `ITPC_TRAP_LEVEL : {1'b0, best_pri};
  wire [23:0] tbl_base = alt_sel_q ? `ITPC_ALT_BASE : `ITPC_PRI_BASE;
  wire [23:0] sel_addr = tbl_base + `ITPC_VEC_OFS + {16'h0, sel_vec, 1'b0};

  // --------------------------------------------------------------------------
  // Presentation latch toward the core
  // --------------------------------------------------------------------------
  // Fields hold their last value while nothing is pending, for software to inspect.
  // The request stays up for one cycle after a take, because arbitration still sees the old level.
  // A core must therefore ignore the request in the cycle after its acknowledge.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_q     <= 1'b0;
      latched_vector_number_q  <= 7'h00;
      ilr_q     <= `ITPC_RST_LEVEL;
      handler_q <= 24'h0;
    end else begin
      req_q <= any_hit;
      if (any_hit) begin
        latched_vector_number_q  <= sel_vec;
        ilr_q     <= sel_lvl;
        handler_q <= sel_addr;
      end
    end
  end

  // --------------------------------------------------------------------------
  // CPU priority level
  // --------------------------------------------------------------------------
  // Taking an interrupt beats a restore, which beats a software write in the same cycle.
  assign level_d = take ? ilr_q :
                   level_restore ? restore_level :
                   (w_sr && !nest_dis_q) ? {level_q[3], reg_wdata[7:5]} :
                   level_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= `ITPC_RST_LEVEL;
    end else begin
      level_q <= level_d;
    end
  end

  // --------------------------------------------------------------------------
  // Event status and summary interrupt
  // --------------------------------------------------------------------------
  // Bit 0 records any trap pulse, bit 1 a taken interrupt; a set in the clear cycle wins.
  wire [1:0] est_set = {take, |trap_req};
  assign est_d = (est_q & ~(w_est ? reg_wdata[1:0] : 2'h0)) | est_set;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      est_q   <= 2'h0;
      emask_q <= 2'h0;
    end else begin
      est_q <= est_d;
      if (w_emsk) emask_q <= reg_wdata[1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  wire        msb      = level_q[`ITPC_IPL_MSB_BIT];
  wire [15:0] rd_c1    = {nest_dis_q, 10'h000, trap_q, 1'b0};
  wire [15:0] rd_c2    = {alt_sel_q, 12'h000, ext_pol_q};
  wire [15:0] rd_vl    = {4'h0, ilr_q, 1'b0, latched_vector_number_q};
  wire [15:0] rd_sr    = {8'h00, level_q[2:0], 5'h00};
  wire [15:0] rd_cc    = {12'h000, msb, 3'h0};
  wire        a_pri    = (reg_addr >= `ITPC_A_PRI_FIRST) && (reg_addr <= `ITPC_A_PRI_LAST);
  // The third flag and enable words stand for unpopulated sources and read zero.
  wire [15:0] rd_mux   = (reg_addr == `ITPC_A_CTRL_ONE)   ? rd_c1 :
                         (reg_addr == `ITPC_A_CTRL_TWO)   ? rd_c2 :
                         (reg_addr == `ITPC_A_FLAG0)      ? flag_q[15:0] :
                         (reg_addr == `ITPC_A_FLAG1)      ? flag_q[31:16] :
                         (reg_addr == `ITPC_A_EN0)        ? en_q[15:0] :
                         (reg_addr == `ITPC_A_EN1)        ? en_q[31:16] :
                         a_pri                            ? pri_q[reg_addr[2:0]] :
                         (reg_addr == `ITPC_A_VEC_LEVEL)  ? rd_vl :
                         (reg_addr == `ITPC_A_CPU_STATUS) ? rd_sr :
                         (reg_addr == `ITPC_A_CORE_CTRL)  ? rd_cc :
                         (reg_addr == `ITPC_A_EVT_STAT)   ? {14'h0, est_q} :
                         (reg_addr == `ITPC_A_EVT_MASK)   ? {14'h0, emask_q} :
                         16'h0000;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `ITPC_RST_WORD;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign reg_rdata          = rdata_q;
  assign irq_req            = req_q;
  assign irq_vector         = latched_vector_number_q;
  assign irq_level          = ilr_q;
  assign irq_handler        = handler_q;
  assign cpu_priority_level = level_q;
  assign evt_irq            = |(est_q & emask_q);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_taken;
    req_q && irq_ack;
  endsequence

  sequence s_sw_only;
    !take && !level_restore;
  endsequence

  // A restore that a take in the same cycle does not overrule.
  sequence s_restored;
    level_restore && !take;
  endsequence

  // Every property watches state and outputs of this block; the far side feeds antecedents and, through $past, expected values.
  // Steps that span a take or a restore are built from the named sequences above.
  a_flag_set_wins: assert property (periph_req[3] && w_f0 |=> flag_q[3])
    else $error("flag lost when set and clear met");

  a_enable_gates: assert property (!(|(flag_q & en_q)) && !trap_hit |=> !req_q)
    else $error("request presented with no enabled flag");

  a_level_seven: assert property (level_q == 4'h7 && !(|trap_q) |=> !req_q)
    else $error("user request passed at level seven");

  a_msb_blocks: assert property (level_q[3] && !trap_hit |=> !req_q)
    else $error("user request passed with level top bit set");

  a_ilr_match: assert property (user_hit && !trap_hit |=> ilr_q == {1'b0, $past(best_pri)})
    else $error("new level differs from presented priority");

  a_level_take: assert property (s_taken |=> level_q == $past(ilr_q))
    else $error("level not raised on acceptance");

  a_nest_lock: assert property ((w_sr && nest_dis_q) and s_sw_only |=> $stable(level_q))
    else $error("status level changed while nesting disabled");

  a_ipl_write: assert property ((w_sr && !nest_dis_q) and s_sw_only |=>
                                level_q[2:0] == $past(reg_wdata[7:5]))
    else $error("status level write not taken");

  a_msb_ro: assert property ((reg_wr && reg_addr == `ITPC_A_CORE_CTRL) and s_sw_only |=>
                             $stable(level_q[3]))
    else $error("software changed level top bit");

  a_table_sel: assert property (any_hit && trap_hit && trap_q[0] |=>
                                irq_handler == ($past(alt_sel_q) ? 24'h000106 : 24'h000006))
    else $error("oscillator trap handler address wrong");

  a_msb_read: assert property (reg_rd && reg_addr == `ITPC_A_CORE_CTRL |=>
                               reg_rdata[3] == ($past(level_q) > 4'h7))
    else $error("level top bit read wrong");

  // Traps carry the fixed trap level and one of the four trap vectors.
  a_trap_vec: assert property (trap_hit |=>
                               irq_level == `ITPC_TRAP_LEVEL && irq_vector >= 7'h01 && irq_vector <= 7'h04)
    else $error("trap presented with wrong vector or level");

  a_user_vec: assert property (user_hit && !trap_hit |=>
                               irq_vector >= `ITPC_USER_VEC0 && irq_level != 4'h0)
    else $error("user request outside the user vectors");

  a_restore_level: assert property (s_restored |=> level_q == $past(restore_level))
    else $error("level not restored");

  // A selected edge on pin 0 must reach the flag of its source one edge later.
  a_ext_flag: assert property (ext_evt[0] |=> flag_q[`ITPC_EXT0_SRC])
    else $error("pin edge did not set its flag");

endmodule // itpc_ctrl

// ---- verilog/itpc_cfg.svh ----
// Offsets, field positions, reset values and fixed settings of the interrupt and trap controller.
`ifndef ITPC_CFG_SVH
`define ITPC_CFG_SVH

// ----------------------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------------------
`define ITPC_A_CTRL_ONE   5'h00
`define ITPC_A_CTRL_TWO   5'h01
`define ITPC_A_FLAG0      5'h02
`define ITPC_A_FLAG1      5'h03
`define ITPC_A_FLAG2      5'h04
`define ITPC_A_EN0        5'h05
`define ITPC_A_EN1        5'h06
`define ITPC_A_EN2        5'h07
`define ITPC_A_PRI_FIRST  5'h08
`define ITPC_A_PRI_LAST   5'h0F
`define ITPC_A_VEC_LEVEL  5'h10
`define ITPC_A_CPU_STATUS 5'h11
`define ITPC_A_CORE_CTRL  5'h12
`define ITPC_A_EVT_STAT   5'h13
`define ITPC_A_EVT_MASK   5'h14

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ITPC_NEST_DIS_BIT 15
`define ITPC_ALT_SEL_BIT  15
`define ITPC_IPL_LSB      5
`define ITPC_IPL_MSB_BIT  3
`define ITPC_PRI_MASK     16'h7777

// ----------------------------------------------------------------------------
// Sizes, source mapping and vector table layout
// ----------------------------------------------------------------------------
`define ITPC_NSRC         32
`define ITPC_NTRAP        4
`define ITPC_NEXT         3
`define ITPC_USER_VEC0    7'h08
`define ITPC_EXT0_SRC     0
`define ITPC_EXT1_SRC     20
`define ITPC_EXT2_SRC     29
`define ITPC_PRI_BASE     24'h000000
`define ITPC_ALT_BASE     24'h000100
`define ITPC_VEC_OFS      24'h000004
`define ITPC_TRAP_LEVEL   4'h8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ITPC_RST_WORD     16'h0000
`define ITPC_RST_LEVEL    4'h0

`endif

// ---- verilog/itpc_pkg.sv ----
// Types shared by the interrupt and trap controller.
package itpc_pkg;
  typedef logic [15:0] itpc_word_t;
  typedef logic [4:0]  itpc_addr_t;
  typedef logic [3:0]  itpc_level_t;
  typedef logic [2:0]  itpc_pri_t;
  typedef logic [6:0]  itpc_vec_t;
  typedef logic [23:0] itpc_paddr_t;
endpackage

// ---- sim/itpc_core_model.sv ----
// Processor core model that takes presented interrupts and returns from them.
`timescale 1ns/1ns

module itpc_core_model
  import itpc_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Bench controls.
  input  wire logic        ack_en,
  input  wire logic [3:0]  ack_dly,
  input  wire logic        ret,
  // Controller side.
  input  wire logic        irq_req,
  input  wire itpc_level_t cpu_priority_level,
  output logic             irq_ack,
  output logic             level_restore,
  output itpc_level_t      restore_level
);
  logic [3:0]  wait_q;
  itpc_level_t saved_q;
  logic        took_q;
  // The request still stands in the cycle after an acknowledge, so that cycle is skipped.
  wire         take_now = irq_req && ack_en && !irq_ack && !took_q && (wait_q == ack_dly);

  // ----------------------------------------------------------------------------
  // Take and return
  // ----------------------------------------------------------------------------
  // A slow core lets the request stand ack_dly cycles; the level is saved so a return can restore it.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q        <= 4'h0;
      saved_q       <= 4'h0;
      irq_ack       <= 1'b0;
      took_q        <= 1'b0;
      level_restore <= 1'b0;
      restore_level <= 4'hF;
    end else begin
      wait_q        <= (!irq_req || irq_ack || !ack_en) ? 4'h0 : wait_q + 4'h1;
      irq_ack       <= take_now;
      took_q        <= irq_ack;
      // The level in force when the core takes an interrupt is what a return brings back.
      saved_q       <= take_now ? cpu_priority_level : saved_q;
      level_restore <= ret;
      // The restore value is only meaningful beside the strobe, so it is scrambled otherwise.
      restore_level <= ret ? saved_q : ~saved_q;
    end
  end
endmodule // itpc_core_model

// ---- sim/testbench.sv ----
// Self-checking testbench of the interrupt and trap controller.
`timescale 1ns/1ns
`include "itpc_cfg.svh"

module testbench
  import itpc_pkg::*;
;
  logic        core_clk, rstn, reg_wr, reg_rd, irq_req, irq_ack, level_restore, evt_irq, ack_en, ret;
  itpc_addr_t  reg_addr;
  itpc_word_t  reg_wdata, reg_rdata;
  logic [31:0] periph_req;
  logic [2:0]  ext_pin;
  logic [3:0]  trap_req, ack_dly;
  itpc_vec_t   irq_vector;
  itpc_level_t irq_level, restore_level, cpu_priority_level;
  itpc_paddr_t irq_handler;
  int          err_count, n_checks;

  itpc_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req), .ext_pin(ext_pin),
    .trap_req(trap_req), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
    .irq_handler(irq_handler), .irq_ack(irq_ack), .level_restore(level_restore),
    .restore_level(restore_level), .cpu_priority_level(cpu_priority_level), .evt_irq(evt_irq));
  itpc_core_model i_core (.core_clk(core_clk), .rstn(rstn), .ack_en(ack_en), .ack_dly(ack_dly), .ret(ret),
    .irq_req(irq_req), .cpu_priority_level(cpu_priority_level), .irq_ack(irq_ack),
    .level_restore(level_restore), .restore_level(restore_level));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input itpc_addr_t a, input itpc_word_t d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are looked at there.
  task automatic rd(input itpc_addr_t a, input itpc_word_t e, input string m);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, e, m);
  endtask
  task automatic pulse(input logic [31:0] p, input logic [3:0] t);
    @(posedge core_clk);
    periph_req <= p;
    trap_req   <= t;
    @(posedge core_clk);
    periph_req <= '0;
    trap_req   <= '0;
    cyc(2);
  endtask
  task automatic do_ret();
    @(posedge core_clk);
    ret <= 1'b1;
    @(posedge core_clk);
    ret <= 1'b0;
    cyc(3);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    chk(irq_req, 1'b0, "irq after reset");
    rd(`ITPC_A_CTRL_ONE, 16'h0000, "ctrl one reset");
    wr(`ITPC_A_VEC_LEVEL, 16'hFFFF);
    rd(`ITPC_A_VEC_LEVEL, 16'h0000, "vector status read-only");
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000, "unmapped read");
  endtask
  task automatic t_basic();
    wr(`ITPC_A_PRI_FIRST, 16'h0003);
    pulse(32'h1, 4'h0);
    chk(irq_req, 1'b0, "disabled source presented");
    rd(`ITPC_A_FLAG0, 16'h0001, "flag not set");
    wr(`ITPC_A_EN0, 16'h0001);
    cyc(2);
    chk({irq_req, irq_vector, irq_level}, {1'b1, 7'd8, 4'd3}, "first source");
    chk(irq_handler, 24'h000014, "primary handler");
    rd(`ITPC_A_VEC_LEVEL, 16'h0308, "vector status");
    wr(`ITPC_A_CTRL_TWO, 16'h8000);
    cyc(2);
    chk(irq_handler, 24'h000114, "alternate handler");
    wr(`ITPC_A_CTRL_TWO, 16'h0000);
    ack_dly <= 4'h5;
    ack_en  <= 1'b1;
    cyc(12);
    ack_en  <= 1'b0;
    chk({irq_req, cpu_priority_level}, {1'b0, 4'd3}, "level after take");
    rd(`ITPC_A_CPU_STATUS, 16'h0060, "status level bits");
    rd(`ITPC_A_EVT_STAT, 16'h0002, "taken event");
    chk(evt_irq, 1'b0, "masked event");
    wr(`ITPC_A_EVT_MASK, 16'h0002);
    cyc(2);
    chk(evt_irq, 1'b1, "unmasked event");
    wr(`ITPC_A_EVT_STAT, 16'h0003);
    cyc(2);
    chk(evt_irq, 1'b0, "event cleared");
    do_ret();
    chk({irq_req, cpu_priority_level}, {1'b1, 4'd0}, "flag survives take");
    wr(`ITPC_A_FLAG0, 16'h0000);
    cyc(2);
    chk(irq_req, 1'b0, "software clear");
  endtask
  task automatic t_prio();
    wr(`ITPC_A_PRI_FIRST + 5'h01, 16'hFFFF);
    rd(`ITPC_A_PRI_FIRST + 5'h01, 16'h7777, "priority fields");
    wr(`ITPC_A_PRI_FIRST, 16'h6550);
    wr(`ITPC_A_EN0, 16'h000F);
    pulse(32'hE, 4'h0);
    chk({irq_vector, irq_level}, {7'd11, 4'd6}, "highest priority");
    wr(`ITPC_A_FLAG0, 16'h0006);
    cyc(2);
    chk({irq_vector, irq_level}, {7'd9, 4'd5}, "tie to lower vector");
    wr(`ITPC_A_FLAG0, 16'h0000);
    wr(`ITPC_A_PRI_FIRST + 5'h04, 16'h0070);
    wr(`ITPC_A_EN1, 16'h0002);
    pulse(32'h0002_0000, 4'h0);
    chk({irq_vector, irq_level}, {7'd25, 4'd7}, "second word source");
    wr(`ITPC_A_CPU_STATUS, 16'h00C0);
    cyc(2);
    chk(irq_req, 1'b1, "above level 6");
    wr(`ITPC_A_CPU_STATUS, 16'h00E0);
    cyc(2);
    chk(irq_req, 1'b0, "level 7 blocks");
    wr(`ITPC_A_CTRL_ONE, 16'h8000);
    wr(`ITPC_A_CPU_STATUS, 16'h0000);
    rd(`ITPC_A_CPU_STATUS, 16'h00E0, "nesting disable write");
    wr(`ITPC_A_CTRL_ONE, 16'h0000);
    wr(`ITPC_A_CPU_STATUS, 16'h0000);
  endtask
  task automatic t_trap();
    for (int i = 0; i < 4; i++) begin
      pulse('0, 4'h1 << i);
      chk({irq_vector, irq_handler}, {7'(i + 1), 24'(4 + 2 * (i + 1))}, "trap vector");
      rd(`ITPC_A_CTRL_ONE, 16'h0002 << i, "trap flag");
      wr(`ITPC_A_CTRL_ONE, 16'h0000);
    end
    pulse('0, 4'h2);
    chk(irq_level, 4'h8, "trap level");
    ack_dly <= 4'h0;
    ack_en  <= 1'b1;
    cyc(4);
    ack_en  <= 1'b0;
    chk({irq_req, cpu_priority_level}, {1'b0, 4'h8}, "user blocked above 7");
    rd(`ITPC_A_CORE_CTRL, 16'h0008, "level top bit");
    wr(`ITPC_A_CORE_CTRL, 16'h0000);
    rd(`ITPC_A_CORE_CTRL, 16'h0008, "top bit read-only");
    wr(`ITPC_A_CPU_STATUS, 16'h00A0);
    cyc(1);
    chk(cpu_priority_level, 4'hD, "level 13");
    do_ret();
    wr(`ITPC_A_CTRL_ONE, 16'h0000);
    cyc(2);
    chk({irq_req, irq_vector}, {1'b1, 7'd25}, "user after trap");
    wr(`ITPC_A_FLAG1, 16'h0000);
  endtask
  task automatic t_ext();
    ext_pin <= 3'b101;
    cyc(4);
    rd(`ITPC_A_FLAG0, 16'h0001, "pin zero rising");
    rd(`ITPC_A_FLAG1, 16'h2000, "pin two rising");
    wr(`ITPC_A_CTRL_TWO, 16'h0001);
    wr(`ITPC_A_FLAG0, 16'h0000);
    ext_pin <= 3'b100;
    cyc(4);
    rd(`ITPC_A_FLAG0, 16'h0001, "pin zero falling");
    // A clear written in the cycle of a new request must lose to it.
    @(posedge core_clk);
    periph_req <= 32'h0000_0008;
    reg_wr     <= 1'b1;
    reg_addr   <= `ITPC_A_FLAG0;
    reg_wdata  <= 16'h0000;
    @(posedge core_clk);
    periph_req <= '0;
    reg_wr     <= 1'b0;
    rd(`ITPC_A_FLAG0, 16'h0008, "set beats clear");
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    rstn       = 1'b0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_addr   = '0;
    reg_wdata  = '0;
    periph_req = '0;
    ext_pin    = '0;
    trap_req   = '0;
    ack_en     = 1'b0;
    ack_dly    = 4'h0;
    ret        = 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    cyc(1);
    t_reset();
    t_basic();
    t_prio();
    t_trap();
    t_ext();
    summarize();
  end
  // The whole sequence takes a few hundred cycles, so a hang is cut well short of the run limit.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end
endmodule // testbench
